// ===== rtl/sar_pkg.sv
// Overview of operation
// - Select fall: hold, sample, start, drive output
// - Sixteen serial clocks per frame, select low
// - Track again at rise after 13 falls
// - Release output at sixteenth falling edge
// - Early select rise abandons, releases output
// - Output changes at select fall and on serial falling edges
// - Four zeros then 12-bit result, MSB first
// - Straight binary, LSB equals reference/4096
// - First zero at select fall, then per edge
// - LSB after fifteenth fall, captured at sixteenth
// - Host allows 290 ns acquisition before select
// - Host waits 60 ns quiet after release
// - Slow clock: host may sample on rises
// - Serial clock drives shifting and approximation
// - Serial clock up to 10 MHz
// - Rise in edges 2..9 enters power-down
// - Rise in edges 10..15 stays powered, abandons
// - Dummy frame past tenth edge powers up
package sar_pkg;
   localparam int          CLK_MHZ        = 50;
   localparam int          RES_W          = 12;
   localparam int          WORD_W         = 16;
   localparam logic [4:0]  FRAME_EDGES    = 5'h10;
   localparam logic [4:0]  TRACK_EDGE     = 5'h0D;
   localparam logic [4:0]  PD_LO_EDGE     = 5'h02;
   localparam logic [4:0]  PD_HI_EDGE     = 5'h0A;
   localparam int          ACQ_NS         = 290;
   localparam int          QUIET_NS       = 60;
   localparam int          PWRUP_NS       = 1000;
   localparam int          SCLK_HALF_NS   = 60;
   localparam int          ACQ_CYC   = (ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam int          QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
   localparam int          PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
   localparam int          HALF_CYC  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int          FIFO_DEPTH     = 8;
   localparam logic [2:0]  SYNC_RST       = 3'h7;
endpackage

// ===== rtl/sar_link_if.sv
`timescale 1ns/1ps
interface sar_link_if;
   logic select_n;
   logic sclk;
   logic serial_result_out;
   logic serial_result_oe;
   modport device (input select_n, input sclk,
                   output serial_result_out, output serial_result_oe);
   modport host   (output select_n, output sclk,
                   input serial_result_out, input serial_result_oe);
endinterface

// ===== rtl/sar_fifo.sv
`timescale 1ns/1ps
module sar_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } sar_fifo_st_t;
   logic [WIDTH-1:0] mem [DEPTH];
   sar_fifo_st_t st_reg, st_next;
   logic push, pop;
   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;
   assign in_ready_o  = st_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = st_reg.cnt != '0;
   assign out_data_o  = mem[st_reg.rd];
   always_comb begin
      st_next = st_reg;
      if (push) st_next.wr = st_reg.wr + 1'b1;
      if (pop)  st_next.rd = st_reg.rd + 1'b1;
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) st_reg <= '0;
      else st_reg <= st_next;
      if (push) mem[st_reg.wr] <= in_data_i;
   end
endmodule

// ===== rtl/sar_device.sv
`timescale 1ns/1ps
module sar_device (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   sar_link_if.device       link,
   input  wire logic [11:0] analog_code_i,
   output logic             track_o,
   output logic             converting_o,
   output logic             powered_down_o,
   output logic             powered_o
);
   typedef struct packed {
      logic [2:0]  cs_sync;
      logic [2:0]  ck_sync;
      logic [4:0]  edges;
      logic        active;
      logic        drive;
      logic        dout;
      logic [15:0] shreg;
      logic        track;
      logic        pd;
      logic [15:0] pwr_cnt;
      logic        powered;
   } sar_dev_st_t;
   sar_dev_st_t s_reg, s_next;
   logic cs_fall, cs_rise, ck_fall, ck_rise;
   assign cs_fall = s_reg.cs_sync[2] && !s_reg.cs_sync[1];
   assign cs_rise = !s_reg.cs_sync[2] && s_reg.cs_sync[1];
   assign ck_fall = s_reg.ck_sync[2] && !s_reg.ck_sync[1];
   assign ck_rise = !s_reg.ck_sync[2] && s_reg.ck_sync[1];
   always_comb begin
      s_next = s_reg;
      s_next.cs_sync = {s_reg.cs_sync[1:0], link.select_n};
      s_next.ck_sync = {s_reg.ck_sync[1:0], link.sclk};
      if (s_reg.pwr_cnt != '0) s_next.pwr_cnt = s_reg.pwr_cnt - 16'h0001;
      if (s_reg.pwr_cnt == 16'h0001) s_next.powered = 1'b1;
      if (cs_fall) begin
         s_next.active = 1'b1;
         s_next.track  = 1'b0;
         s_next.drive  = 1'b1;
         s_next.edges  = '0;
         // Straight binary sample latched at select fall
         s_next.shreg  = {4'h0, analog_code_i};
         s_next.dout   = 1'b0;
         if (s_reg.pd) s_next.pwr_cnt = 16'(sar_pkg::PWRUP_CYC);
      end else if (cs_rise && s_reg.active) begin
         s_next.active = 1'b0;
         s_next.drive  = 1'b0;
         if (s_reg.edges >= sar_pkg::PD_LO_EDGE
             && s_reg.edges < sar_pkg::PD_HI_EDGE) begin
            s_next.pd      = 1'b1;
            s_next.powered = 1'b0;
            s_next.pwr_cnt = '0;
         end else if (s_reg.edges >= sar_pkg::PD_HI_EDGE
                      && s_reg.edges < sar_pkg::FRAME_EDGES) begin
            s_next.pd = 1'b0;
         end else if (s_reg.pd) begin
            s_next.pwr_cnt = '0;
         end
      end else if (s_reg.active && ck_fall) begin
         s_next.edges = s_reg.edges + 5'h01;
         s_next.shreg = {s_reg.shreg[14:0], 1'b0};
         s_next.dout  = s_reg.shreg[14];
         if (s_reg.edges + 5'h01 == sar_pkg::PD_HI_EDGE)
            s_next.pd = 1'b0;
         if (s_reg.edges + 5'h01 == sar_pkg::FRAME_EDGES) begin
            s_next.drive  = 1'b0;
            s_next.active = 1'b0;
            s_next.dout   = 1'b0;
         end
      end else if (s_reg.active && ck_rise
                   && s_reg.edges == sar_pkg::TRACK_EDGE) begin
         s_next.track = 1'b1;
      end
      if (!s_reg.active && !s_reg.pd && !cs_fall) s_next.track = 1'b1;
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_reg         <= '0;
         s_reg.cs_sync <= sar_pkg::SYNC_RST;
         s_reg.track   <= 1'b1;
         s_reg.powered <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   assign link.serial_result_out = s_reg.dout;
   assign link.serial_result_oe  = s_reg.drive;
   assign track_o        = s_reg.track;
   assign converting_o   = s_reg.active;
   assign powered_down_o = s_reg.pd;
   assign powered_o      = s_reg.powered;
endmodule

// ===== rtl/sar_host.sv
`timescale 1ns/1ps
module sar_host (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   sar_link_if.host         link,
   input  wire logic        start_i,
   input  wire logic [4:0]  edge_count_i,
   output logic             busy_o,
   output logic [11:0]      result_o,
   output logic             result_valid_o,
   input  wire logic        result_ready_i
);
   typedef enum logic [1:0] {
      HS_IDLE  = 2'b00,
      HS_RUN   = 2'b01,
      HS_QUIET = 2'b10
   } sar_hs_t;
   typedef struct packed {
      sar_hs_t     state;
      logic        sel_n;
      logic        sclk;
      logic [7:0]  div;
      logic [4:0]  falls;
      logic [4:0]  target;
      logic [15:0] word;
      logic [7:0]  wait_cnt;
      logic [2:0]  din_sync;
      logic        push;
      logic        busy;
   } sar_host_st_t;
   sar_host_st_t h_reg, h_next;
   logic fifo_ready;
   logic [11:0] fifo_data;
   logic fifo_valid;
   always_comb begin
      h_next = h_reg;
      h_next.din_sync = {h_reg.din_sync[1:0], link.serial_result_out};
      h_next.push = 1'b0;
      unique case (h_reg.state)
         HS_IDLE: begin
            h_next.busy = 1'b0;
            if (start_i && fifo_ready && edge_count_i != '0) begin
               h_next.state  = HS_RUN;
               h_next.sel_n  = 1'b0;
               h_next.busy   = 1'b1;
               h_next.falls  = '0;
               h_next.div    = 8'(sar_pkg::HALF_CYC);
               h_next.target = edge_count_i;
            end
         end
         HS_RUN: begin
            if (h_reg.div != 8'h00) h_next.div = h_reg.div - 8'h01;
            else begin
               h_next.div  = 8'(sar_pkg::HALF_CYC);
               if (h_reg.sclk) begin
                  // Capture on falls only, LSB at 16th; rise option unused
                  h_next.sclk  = 1'b0;
                  h_next.word = {h_reg.word[14:0], h_reg.din_sync[2]};
                  h_next.falls = h_reg.falls + 5'h01;
               end else if (h_reg.falls == h_reg.target) begin
                  // Clock parks low; no extra rise beside select rise
                  h_next.sel_n    = 1'b1;
                  h_next.state    = HS_QUIET;
                  h_next.wait_cnt = 8'(sar_pkg::ACQ_CYC
                                    + sar_pkg::QUIET_CYC);
                  h_next.push = h_reg.falls == sar_pkg::FRAME_EDGES;
               end else begin
                  h_next.sclk = 1'b1;
               end
            end
         end
         HS_QUIET: begin
            if (h_reg.wait_cnt != 8'h00)
               h_next.wait_cnt = h_reg.wait_cnt - 8'h01;
            else h_next.state = HS_IDLE;
         end
         default: h_next.state = HS_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         h_reg       <= '0;
         h_reg.state <= HS_IDLE;
         h_reg.sel_n <= 1'b1;
      end else begin
         h_reg <= h_next;
      end
   end
   sar_fifo #(.WIDTH(12), .DEPTH(sar_pkg::FIFO_DEPTH)) u_fifo (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_data_i   (h_reg.word[11:0]),
      .in_valid_i  (h_reg.push),
      .in_ready_o  (fifo_ready),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (result_ready_i)
   );
   assign link.select_n  = h_reg.sel_n;
   assign link.sclk      = h_reg.sclk;
   assign busy_o         = h_reg.busy;
   assign result_o       = fifo_data;
   assign result_valid_o = fifo_valid;
endmodule

// ===== testbench/sar_link_sva.sv
`timescale 1ns/1ps
module sar_link_sva (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic serial_result_out,
   input wire logic serial_result_oe
);
   localparam int ACQ_MIN = sar_pkg::ACQ_CYC;
   localparam int QUIET_MIN = sar_pkg::QUIET_CYC;
   logic       sclk_reg;
   logic [4:0] falls_reg;
   logic [7:0] settle_reg;
   logic [7:0] hi_reg;
   logic [7:0] quiet_reg;
   wire        sclk_fall = sclk_reg & ~sclk;
   // Falls per frame, cycles since fall, high and quiet spans
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sclk_reg <= 1'b0;
         falls_reg <= 5'h00;
         settle_reg <= 8'hFF;
         hi_reg <= 8'hFF;
         quiet_reg <= 8'hFF;
      end else begin
         sclk_reg <= sclk;
         if (!select_n && hi_reg != 8'h00)
            falls_reg <= 5'h00;
         else if (sclk_fall && !select_n && falls_reg != 5'h1F)
            falls_reg <= falls_reg + 5'h01;
         settle_reg <= sclk_fall ? 8'h00
                       : settle_reg + 8'(settle_reg != 8'hFF);
         hi_reg <= select_n ? hi_reg + 8'(hi_reg != 8'hFF) : 8'h00;
         quiet_reg <= serial_result_oe ? 8'h00
                      : quiet_reg + 8'(quiet_reg != 8'hFF);
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Sixteenth fall seen while framed
   sequence s_last_fall;
      sclk_fall && falls_reg == 5'h0F && !select_n;
   endsequence
   // Data step while output stays driven
   sequence s_data_step;
      serial_result_oe && $past(serial_result_oe)
      && $changed(serial_result_out);
   endsequence
   a_oe_on_select: assert property (
      $fell(select_n) |-> ##[1:6] serial_result_oe)
      else $error("output not enabled after select fall");
   a_release_early: assert property (
      $rose(select_n) |-> ##[0:6] !serial_result_oe)
      else $error("output not released after select rise");
   a_release_end: assert property (
      s_last_fall |-> ##[1:6] !serial_result_oe)
      else $error("output not released at last fall");
   a_data_on_fall: assert property (
      s_data_step |-> settle_reg inside {[2:6]})
      else $error("data changed away from serial fall");
   a_lead_zeros: assert property (
      serial_result_oe && falls_reg < 5'h04 && settle_reg > 8'h06
      |-> !serial_result_out)
      else $error("leading bit not zero");
   a_host_falls: assert property (
      $rose(select_n) |-> falls_reg <= 5'h10)
      else $error("more than sixteen falls in frame");
   a_acq_gap: assert property (
      $fell(select_n) |-> hi_reg >= ACQ_MIN)
      else $error("acquisition gap too short");
   a_quiet_gap: assert property (
      $fell(select_n) |-> quiet_reg >= QUIET_MIN)
      else $error("quiet gap too short");
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        start_i = 1'b0;
   logic        result_ready_i = 1'b0;
   logic        drain_en = 1'b0;
   logic [4:0]  edge_count_i = 5'h10;
   logic [11:0] analog_code_i = 12'h000;
   logic [11:0] result_o;
   logic        busy_o;
   logic        result_valid_o;
   logic        track_o;
   logic        converting_o;
   logic        powered_down_o;
   logic        powered_o;
   logic        sclk_q = 1'b0;
   logic [15:0] wire_word = 16'h0000;
   logic [11:0] exp_q[$];
   bit          pd_exp = 1'b0;
   bit          ok_res = 1'b0;
   int          bad_count = 0;
   int          comparisons = 0;
   sar_link_if lnk ();
   sar_device i_sar_device (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .link(lnk), .analog_code_i(analog_code_i), .track_o(track_o),
      .converting_o(converting_o), .powered_down_o(powered_down_o),
      .powered_o(powered_o));
   sar_host i_sar_host (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .link(lnk), .start_i(start_i), .edge_count_i(edge_count_i),
      .busy_o(busy_o), .result_o(result_o), .result_valid_o(result_valid_o),
      .result_ready_i(result_ready_i));
   sar_link_sva i_sar_link_sva (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .select_n(lnk.select_n), .sclk(lnk.sclk),
      .serial_result_out(lnk.serial_result_out),
      .serial_result_oe(lnk.serial_result_oe));
   always #10 core_clk_i = ~core_clk_i;
   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_busy(input logic v);
      for (int k = 0; k < 2000 && busy_o !== v; k++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk(busy_o === v, "busy wait");
   endtask
   task automatic frame(input int n);
      logic [11:0] code;
      code = 12'($urandom);
      analog_code_i = code;
      edge_count_i = 5'(n);
      // Model entry made before the result can reach the FIFO output
      if (n == 16)
         exp_q.push_back(code);
      start_i = 1'b1;
      wait_busy(1'b1);
      start_i = 1'b0;
      if (!pd_exp) begin
         repeat (6) @(posedge core_clk_i);
         #1 chk(track_o === 1'b0, "not holding");
         if (n == 16) begin
            // 13th fall near cycle 104, following rise near 108
            repeat (100) @(posedge core_clk_i);
            #1 chk(track_o === 1'b0, "tracking early");
            repeat (8) @(posedge core_clk_i);
            #1 chk(track_o === 1'b1, "no track at rise");
         end
      end
      wait_busy(1'b0);
      repeat (8) @(posedge core_clk_i);
      #1;
      if (n == 16) begin
         chk(wire_word === {4'h0, code}, "serial word");
         chk(track_o === 1'b1, "not tracking");
      end
      if (n >= 2 && n <= 9)
         pd_exp = 1'b1;
      else if (n >= 10)
         pd_exp = 1'b0;
      chk(powered_down_o === pd_exp, "mode");
      if (n >= 10)
         chk(powered_o === 1'b1, "not powered");
      else
         chk(powered_o === 1'b0, "still powered");
   endtask
   // Wire capture at host falls, FIFO drain against model
   always @(posedge core_clk_i) begin
      sclk_q <= lnk.sclk;
      if (!lnk.select_n && sclk_q && !lnk.sclk)
         wire_word <= {wire_word[14:0], lnk.serial_result_out};
      if (result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
         ok_res = exp_q.size() != 0;
         if (ok_res)
            ok_res = result_o === exp_q.pop_front();
         chk(ok_res, "result");
      end
      #1 result_ready_i = drain_en & 1'($urandom);
   end
   initial begin
      repeat (60000) @(posedge core_clk_i);
      bad_count++;
      wrap_up();
   end
   initial begin
      int n;
      int tbl[6] = '{2, 10, 9, 15, 16, 16};
      void'($urandom(32'h7F7DCAA4));
      repeat (2) @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      repeat (8) frame(16);
      start_i = 1'b1;
      repeat (40) @(posedge core_clk_i);
      #1;
      chk(busy_o === 1'b0 && lnk.select_n === 1'b1, "fifo full");
      start_i = 1'b0;
      drain_en = 1'b1;
      for (int i = 0; i < 30; i++) begin
         n = (i < 6) ? tbl[i] : 2 + int'($urandom % 15);
         if (pd_exp && n == 16)
            n = 12;
         frame(n);
      end
      repeat (400) @(posedge core_clk_i);
      chk(exp_q.size() == 0, "results missing");
      wrap_up();
   end
endmodule
